// ==== hw/dsu_pkg.sv ====
// Constants shared by the debug serial unit receiver and its baud generator.
package dsu_pkg;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_IEN = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_HOLD = 8'h10;
    localparam logic [7:0] OFS_BAUD = 8'h14;
    localparam logic [7:0] OFS_FRST = 8'h18;

    // ------------------------------------------------------------------
    // Control command bits
    // ------------------------------------------------------------------
    localparam int CMD_RX_RESET = 2;
    localparam int CMD_RX_ENABLE = 4;
    localparam int CMD_RX_DISABLE = 5;
    localparam int CMD_CLEAR_STATUS = 8;

    // ------------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------------
    localparam int ST_RX_READY = 0;
    localparam int ST_RX_ENABLED = 1;
    localparam int ST_OVERRUN = 5;
    localparam int ST_FRAME = 6;
    localparam int ST_PARITY = 7;
    localparam int ST_COMM_TX = 30;
    localparam int ST_COMM_RX = 31;

    // ------------------------------------------------------------------
    // Mode and widths
    // ------------------------------------------------------------------
    localparam int PAR_LSB = 0;
    localparam int PAR_W = 3;
    localparam logic [2:0] PAR_EVEN = 3'h0;
    localparam logic [2:0] PAR_ODD = 3'h1;
    localparam logic [2:0] PAR_SPACE = 3'h2;
    localparam logic [2:0] PAR_MARK = 3'h3;
    localparam logic [2:0] PAR_RESET = 3'h4;
    localparam int DIV_W = 16;
    localparam int CHAR_W = 8;

    // ------------------------------------------------------------------
    // Sampling timing, in sampling-clock ticks counted from the falling edge
    // ------------------------------------------------------------------
    localparam int OVERSAMPLE = 16;
    localparam logic [4:0] START_QUAL = 5'h07;
    localparam logic [4:0] FIRST_SAMPLE = 5'h18;
    localparam logic [4:0] SAMPLE_LAST = FIRST_SAMPLE - 5'h01;
    localparam logic [4:0] SAMPLE_RELOAD = FIRST_SAMPLE - 5'(OVERSAMPLE);
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------------
    // Receiver states, Gray coded along the path
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_OFF = 2'h0,
        RX_HUNT = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } dsu_rx_state_t;

endpackage

// ==== hw/dsu_baud_if.sv ====
// Link between the receiver and its baud rate generator.
`timescale 1ns/10ps
`default_nettype none
interface dsu_baud_if;
    logic [dsu_pkg::DIV_W-1:0] divisor;
    logic tick;
    modport gen (input divisor, output tick);
    modport user (output divisor, input tick);
endinterface
`default_nettype wire

// ==== hw/dsu_baud_gen.sv ====
// Baud rate generator producing the sixteen-times sampling tick.
`timescale 1ns/10ps
`default_nettype none
module dsu_baud_gen
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Divisor in, tick out
    dsu_baud_if.gen baud
);

    logic [dsu_pkg::DIV_W-1:0] cnt_r;
    logic tick_r;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // One tick every divisor clocks gives sixteen ticks per bit. A zero
    // divisor holds the counter so no tick is ever produced.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else if (baud.divisor == '0)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else if (cnt_r >= baud.divisor - 16'h0001)
        begin
            cnt_r <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    assign baud.tick = tick_r;

endmodule // dsu_baud_gen
`default_nettype wire

// ==== hw/dsu_uart.sv ====
// Debug serial unit: register port, receiver, debug channel status and test reset force.
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module dsu_uart
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [dsu_pkg::ADDR_W-1:0] addr_i,
    input wire logic [dsu_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [dsu_pkg::DATA_W-1:0] rdata_o,
    // Serial pins
    input wire logic serial_rx_pin_i,
    output logic serial_tx_pin_o,
    // Debug comms channel and emulator reset
    input wire logic comm_rx_full_i,
    input wire logic comm_tx_full_i,
    output logic emulator_test_reset_n_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] in_meta_r;
    logic [2:0] in_sync_r;
    logic rx_line;
    logic comm_rx;
    logic comm_tx;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_meta_r <= 3'h7;
            in_sync_r <= 3'h7;
        end
        else
        begin
            in_meta_r <= {comm_tx_full_i, comm_rx_full_i, serial_rx_pin_i};
            in_sync_r <= in_meta_r;
        end
    end

    assign rx_line = in_sync_r[0];
    assign comm_rx = in_sync_r[1];
    assign comm_tx = in_sync_r[2];

    // ------------------------------------------------------------------
    // Register write and hold read decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [dsu_pkg::ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic cmd_wr;
    logic cmd_reset;
    logic cmd_enable;
    logic cmd_disable;
    logic cmd_clear;
    logic hold_read;

    assign cmd_wr = wr_i && hit(addr_i, dsu_pkg::OFS_CTRL);
    assign cmd_reset = cmd_wr && wdata_i[dsu_pkg::CMD_RX_RESET];
    assign cmd_enable = cmd_wr && wdata_i[dsu_pkg::CMD_RX_ENABLE];
    assign cmd_disable = cmd_wr && wdata_i[dsu_pkg::CMD_RX_DISABLE];
    assign cmd_clear = cmd_wr && wdata_i[dsu_pkg::CMD_CLEAR_STATUS];
    assign hold_read = rd_i && hit(addr_i, dsu_pkg::OFS_HOLD);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [dsu_pkg::PAR_W-1:0] parity_type_field_r;
    logic [dsu_pkg::DATA_W-1:0] ien_r;
    logic force_test_reset_r;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            parity_type_field_r <= dsu_pkg::PAR_RESET;
            ien_r <= '0;
            force_test_reset_r <= 1'b0;
        end
        else if (wr_i)
        begin
            if (hit(addr_i, dsu_pkg::OFS_MODE))
            begin
                parity_type_field_r <= wdata_i[dsu_pkg::PAR_LSB +: dsu_pkg::PAR_W];
            end
            if (hit(addr_i, dsu_pkg::OFS_IEN))
            begin
                ien_r <= wdata_i;
            end
            if (hit(addr_i, dsu_pkg::OFS_FRST))
            begin
                force_test_reset_r <= wdata_i[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    dsu_baud_if baud ();
    logic [dsu_pkg::DIV_W-1:0] baud_divisor_r;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            baud_divisor_r <= '0;
        end
        else if (wr_i && hit(addr_i, dsu_pkg::OFS_BAUD))
        begin
            baud_divisor_r <= wdata_i[dsu_pkg::DIV_W-1:0];
        end
    end

    assign baud.divisor = baud_divisor_r;

    // The receiver and the (unimplemented) transmitter share this tick.
    dsu_baud_gen u_baud (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .baud(baud.gen)
    );

    // ------------------------------------------------------------------
    // Receiver state machine
    // ------------------------------------------------------------------
    dsu_pkg::dsu_rx_state_t state_r;
    logic rx_en_r;
    logic [4:0] phase_r;
    logic [2:0] bit_r;
    logic [dsu_pkg::CHAR_W-1:0] shift_r;
    logic par_bit_r;
    logic par_phase_r;
    logic parity_on;
    logic sample_now;
    logic char_done;

    assign parity_on = !parity_type_field_r[2];
    assign sample_now = baud.tick && (phase_r == dsu_pkg::SAMPLE_LAST);
    assign char_done = (state_r == dsu_pkg::RX_STOP) && sample_now;

    // Disable wins over enable when both are written together.
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_en_r <= 1'b0;
        end
        else if (cmd_reset || cmd_disable)
        begin
            rx_en_r <= 1'b0;
        end
        else if (cmd_enable)
        begin
            rx_en_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= dsu_pkg::RX_OFF;
            phase_r <= '0;
            bit_r <= '0;
            shift_r <= '0;
            par_bit_r <= 1'b0;
            par_phase_r <= 1'b0;
        end
        else if (cmd_reset)
        begin
            state_r <= dsu_pkg::RX_OFF;
            phase_r <= '0;
        end
        else
        begin
            case (state_r)
                dsu_pkg::RX_OFF:
                begin
                    phase_r <= '0;
                    if (cmd_enable && !cmd_disable)
                    begin
                        state_r <= dsu_pkg::RX_HUNT;
                    end
                end
                dsu_pkg::RX_HUNT:
                begin
                    if (cmd_disable)
                    begin
                        state_r <= dsu_pkg::RX_OFF;
                        phase_r <= '0;
                    end
                    else if (baud.tick)
                    begin
                        if (rx_line)
                        begin
                            phase_r <= '0;
                        end
                        else if (phase_r == dsu_pkg::START_QUAL)
                        begin
                            // Eighth low tick: the start bit is valid.
                            state_r <= dsu_pkg::RX_DATA;
                            phase_r <= phase_r + 5'h01;
                            bit_r <= '0;
                            par_phase_r <= 1'b0;
                        end
                        else
                        begin
                            phase_r <= phase_r + 5'h01;
                        end
                    end
                end
                dsu_pkg::RX_DATA:
                begin
                    if (baud.tick)
                    begin
                        phase_r <= phase_r + 5'h01;
                    end
                    if (sample_now)
                    begin
                        phase_r <= dsu_pkg::SAMPLE_RELOAD;
                        if (par_phase_r)
                        begin
                            par_bit_r <= rx_line;
                            state_r <= dsu_pkg::RX_STOP;
                        end
                        else
                        begin
                            shift_r <= {rx_line, shift_r[dsu_pkg::CHAR_W-1:1]};
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == dsu_pkg::LAST_BIT)
                            begin
                                par_phase_r <= parity_on;
                                if (!parity_on)
                                begin
                                    state_r <= dsu_pkg::RX_STOP;
                                end
                            end
                        end
                    end
                end
                dsu_pkg::RX_STOP:
                begin
                    if (baud.tick)
                    begin
                        phase_r <= phase_r + 5'h01;
                    end
                    if (sample_now)
                    begin
                        phase_r <= '0;
                        // A pending disable takes effect only here.
                        // A command written in this very cycle is honoured as well.
                        state_r <= ((rx_en_r || cmd_enable) && !cmd_disable)
                            ? dsu_pkg::RX_HUNT : dsu_pkg::RX_OFF;
                    end
                end
                default:
                begin
                    state_r <= dsu_pkg::RX_OFF;
                    phase_r <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Parity check
    // ------------------------------------------------------------------
    logic par_expect;
    logic par_bad;

    always_comb
    begin
        case (parity_type_field_r)
            dsu_pkg::PAR_EVEN: par_expect = ^shift_r;
            dsu_pkg::PAR_ODD: par_expect = ~^shift_r;
            dsu_pkg::PAR_SPACE: par_expect = 1'b0;
            dsu_pkg::PAR_MARK: par_expect = 1'b1;
            default: par_expect = par_bit_r;
        endcase
    end

    assign par_bad = parity_on && (par_bit_r != par_expect);

    // ------------------------------------------------------------------
    // Holding register and status flags
    // ------------------------------------------------------------------
    logic [dsu_pkg::CHAR_W-1:0] rx_holding_reg_r;
    logic rx_ready_flag_r;
    logic rx_overrun_flag_r;
    logic rx_parity_error_flag_r;
    logic rx_frame_error_flag_r;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_holding_reg_r <= '0;
        end
        else if (char_done)
        begin
            rx_holding_reg_r <= shift_r;
        end
    end

    // A completing character in the same cycle as a read keeps ready set.
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_ready_flag_r <= 1'b0;
        end
        else if (char_done)
        begin
            rx_ready_flag_r <= 1'b1;
        end
        else if (hold_read)
        begin
            rx_ready_flag_r <= 1'b0;
        end
    end

    // Error flags are sticky; a new error in the clear cycle wins.
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_overrun_flag_r <= 1'b0;
            rx_parity_error_flag_r <= 1'b0;
            rx_frame_error_flag_r <= 1'b0;
        end
        else
        begin
            rx_overrun_flag_r <= (rx_overrun_flag_r && !cmd_clear)
                || (char_done && rx_ready_flag_r && !hold_read);
            rx_parity_error_flag_r <= (rx_parity_error_flag_r && !cmd_clear)
                || (char_done && par_bad);
            rx_frame_error_flag_r <= (rx_frame_error_flag_r && !cmd_clear)
                || (char_done && !rx_line);
        end
    end

    // ------------------------------------------------------------------
    // Status word, read data and interrupt
    // ------------------------------------------------------------------
    logic [dsu_pkg::DATA_W-1:0] status;

    always_comb
    begin
        status = '0;
        status[dsu_pkg::ST_RX_READY] = rx_ready_flag_r;
        status[dsu_pkg::ST_RX_ENABLED] = rx_en_r;
        status[dsu_pkg::ST_OVERRUN] = rx_overrun_flag_r;
        status[dsu_pkg::ST_FRAME] = rx_frame_error_flag_r;
        status[dsu_pkg::ST_PARITY] = rx_parity_error_flag_r;
        status[dsu_pkg::ST_COMM_TX] = comm_tx;
        status[dsu_pkg::ST_COMM_RX] = comm_rx;
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_o <= '0;
        end
        else if (rd_i)
        begin
            case (addr_i)
                dsu_pkg::OFS_MODE: rdata_o <= 32'(parity_type_field_r);
                dsu_pkg::OFS_IEN: rdata_o <= ien_r;
                dsu_pkg::OFS_STAT: rdata_o <= status;
                dsu_pkg::OFS_HOLD: rdata_o <= 32'(rx_holding_reg_r);
                dsu_pkg::OFS_BAUD: rdata_o <= 32'(baud_divisor_r);
                dsu_pkg::OFS_FRST: rdata_o <= 32'(force_test_reset_r);
                default: rdata_o <= '0;
            endcase
        end
        else
        begin
            rdata_o <= '0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(status & ien_r);
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // The transmitter is outside this block; the line rests at idle high.
    assign serial_tx_pin_o = 1'b1;
    assign emulator_test_reset_n_o = !force_test_reset_r;

endmodule // dsu_uart
`default_nettype wire

// ==== verification/dsu_uart_asserts.sv ====
// Port-level checks for the debug serial unit.
`timescale 1ns/10ps
`default_nettype none
module dsu_uart_asserts
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register port and pins
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic comm_rx_full_i,
    input wire logic emulator_test_reset_n_o
);
    logic rs, rh, wc, wf;
    assign rs = rd_i && addr_i == dsu_pkg::OFS_STAT;
    assign rh = rd_i && addr_i == dsu_pkg::OFS_HOLD;
    assign wc = wr_i && addr_i == dsu_pkg::OFS_CTRL;
    assign wf = wr_i && addr_i == dsu_pkg::OFS_FRST;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    a_hold_clears_ready: assert property (rh ##2 rs |=> !rdata_o[0])
        else $error("ready still set after hold read");
    a_enable_shows_on: assert property (wc && wdata_i[4] && !wdata_i[5] && !wdata_i[2] ##2 rs |=> rdata_o[1])
        else $error("receiver not enabled");
    a_reset_turns_off: assert property (wc && wdata_i[2] ##2 rs |=> !rdata_o[1])
        else $error("receiver still enabled after reset");
    a_force_sets_pin: assert property (wf |=> emulator_test_reset_n_o == !$past(wdata_i[0]))
        else $error("test reset pin wrong after write");
    a_force_pin_holds: assert property (!wf |=> $stable(emulator_test_reset_n_o))
        else $error("test reset pin moved without write");
    a_comm_flag_shown: assert property (rs && $past(comm_rx_full_i, 2) == $past(comm_rx_full_i, 3)
        |=> rdata_o[31] == $past(comm_rx_full_i, 3))
        else $error("channel flag wrong in status");
    a_ctrl_reads_zero: assert property (rd_i && addr_i == dsu_pkg::OFS_CTRL |=> rdata_o == 32'h0)
        else $error("control read not zero");
    a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside answer cycle");
endmodule // dsu_uart_asserts
bind dsu_uart dsu_uart_asserts i_chk (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .comm_rx_full_i, .emulator_test_reset_n_o);
`default_nettype wire

// ==== verification/dsu_term_model.sv ====
// Remote serial terminal model driving the receive line.
`timescale 1ns/10ps
`default_nettype none
module dsu_term_model
(
    // Clock and line
    input wire logic clock_i,
    output logic line_o
);
    int bit_clks = 16;
    initial line_o = 1'b1;
    task automatic hold(input logic v, input int n);
        line_o <= v;
        repeat (n) @(posedge clock_i);
    endtask
    // A negative parity argument sends no parity bit.
    task automatic send(input logic [7:0] b, input int p, input logic stp);
        hold(1'b0, bit_clks);
        for (int i = 0; i < 8; i++)
            hold(b[i], bit_clks);
        if (p >= 0)
            hold(p[0], bit_clks);
        // A low stop is cut short so its tail is not taken for a new start bit.
        hold(stp, stp ? bit_clks : bit_clks * 3 / 4);
        if (!stp)
            hold(1'b1, bit_clks);
    endtask
endmodule // dsu_term_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench for the debug serial unit receiver.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic crx = 1'b0;
    logic ctx = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rx, tx, emu_n, irq;
    int fail_count = 0;
    int total_checks = 0;
    int dv, m_en, m_rdy, m_ovr, m_frm, m_par, m_hold;
    int m_mode = 4;
    initial
    begin
        forever #20 clock_i = ~clock_i;
    end
    dsu_uart i_dut (.clock_i, .nrst_i, .addr_i(addr), .wdata_i(wdata), .wr_i, .rd_i, .rdata_o(rdata),
        .serial_rx_pin_i(rx), .serial_tx_pin_o(tx), .comm_rx_full_i(crx), .comm_tx_full_i(ctx),
        .emulator_test_reset_n_o(emu_n), .irq_o(irq));
    dsu_term_model i_term (.clock_i, .line_o(rx));
    task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", w, exp, seen);
        end
    endtask
    // A spare edge after each strobe keeps two calls from touching one strobe in one step.
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string w);
        addr <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(w, rdata, exp);
        @(posedge clock_i);
    endtask
    task automatic cmd(input int b);
        wreg(dsu_pkg::OFS_CTRL, 32'h1 << b);
    endtask
    task automatic st(input string w);
        rchk(dsu_pkg::OFS_STAT, {crx, ctx, 22'h0, m_par[0], m_frm[0], m_ovr[0], 3'h0, m_en[0], m_rdy[0]}, w);
    endtask
    task automatic rx_char(input logic [7:0] b, input int bad, input logic stp);
        int p;
        int e;
        e = m_en;
        p = m_mode == 0 ? int'(^b) : m_mode == 1 ? int'(~^b) : m_mode - 2;
        i_term.send(b, m_mode < 4 ? p ^ bad : -1, stp);
        repeat (4) @(posedge clock_i);
        if (e != 0)
        begin
            m_ovr |= m_rdy;
            m_rdy = 1;
            m_hold = b;
            m_frm |= !stp;
            m_par |= bad;
        end
    endtask
    task automatic take(input string w);
        st(w);
        rchk(dsu_pkg::OFS_HOLD, 32'(m_hold), w);
        m_rdy = 0;
        st(w);
        cmd(dsu_pkg::CMD_CLEAR_STATUS);
        m_ovr = 0;
        m_frm = 0;
        m_par = 0;
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clock_i);
        fail_count++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'hC812));
        dv = 1 + $urandom % 3;
        i_term.bit_clks = 16 * dv;
        repeat (3) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        wreg(dsu_pkg::OFS_BAUD, 32'(dv));
        rx_char(8'h5A, 0, 1'b1);
        st("off");
        rchk(8'h1C, 32'h0, "unmapped");
        rchk(dsu_pkg::OFS_CTRL, 32'h0, "control");
        rchk(dsu_pkg::OFS_BAUD, 32'(dv), "baud");
        cmd(dsu_pkg::CMD_RX_ENABLE);
        m_en = 1;
        st("on");
        for (int i = 0; i < 12; i++)
        begin
            m_mode = i < 4 ? 4 : (i - 4) / 2;
            wreg(dsu_pkg::OFS_MODE, 32'(m_mode));
            rx_char(8'($urandom), i < 4 ? 0 : i % 2, 1'b1);
            take("char");
        end
        m_mode = 4;
        wreg(dsu_pkg::OFS_MODE, 32'h4);
        rchk(dsu_pkg::OFS_MODE, 32'h4, "mode");
        rx_char(8'($urandom), 0, 1'b1);
        rx_char(8'($urandom), 0, 1'b0);
        take("overrun");
        $display("Test reception done");
        i_term.hold(1'b0, 7 * dv);
        i_term.hold(1'b1, 160 * dv);
        st("short low");
        i_term.hold(1'b0, 8 * dv);
        i_term.hold(1'b1, 160 * dv);
        m_rdy = 1;
        m_hold = 255;
        take("short start");
        $display("Test start detection done");
        fork
            rx_char(8'($urandom), 0, 1'b1);
            begin
                repeat (80 * dv) @(posedge clock_i);
                cmd(dsu_pkg::CMD_RX_DISABLE);
                m_en = 0;
            end
        join
        take("disable");
        rx_char(8'h00, 0, 1'b1);
        st("disabled");
        cmd(dsu_pkg::CMD_RX_ENABLE);
        m_en = 1;
        fork
            i_term.send(8'h00, -1, 1'b1);
            begin
                repeat (80 * dv) @(posedge clock_i);
                cmd(dsu_pkg::CMD_RX_RESET);
                m_en = 0;
                st("reset");
            end
        join
        repeat (4) @(posedge clock_i);
        st("dropped");
        wreg(dsu_pkg::OFS_BAUD, 32'h0);
        cmd(dsu_pkg::CMD_RX_ENABLE);
        m_en = 1;
        i_term.send(8'h00, -1, 1'b1);
        repeat (4) @(posedge clock_i);
        st("divisor zero");
        $display("Test control commands done");
        crx <= 1'b1;
        ctx <= 1'b1;
        repeat (6) @(posedge clock_i);
        st("channel");
        wreg(dsu_pkg::OFS_IEN, 32'h8000_0000);
        wreg(dsu_pkg::OFS_FRST, 32'h1);
        rchk(dsu_pkg::OFS_FRST, 32'h1, "force");
        rchk(dsu_pkg::OFS_IEN, 32'h8000_0000, "mask");
        @(negedge clock_i);
        chk("irq", 32'(irq), 32'h1);
        chk("test reset", 32'(emu_n), 32'h0);
        chk("tx idle", 32'(tx), 32'h1);
        $display("Test channel done");
        end_of_test();
    end
endmodule // tb
`default_nettype wire
